/* File: src/rsmo_regs.vh */
`ifndef RSMO_REGS_VH
`define RSMO_REGS_VH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define RSMO_OP_POP        16'h0006
`define RSMO_OP_PUSH       16'h0005
`define RSMO_OP_RESET      16'h00FF
`define RSMO_RELATIVE_CALL_OP_PREFIX  5'h1B
`define RSMO_RELATIVE_CALL_OP_PFX_MSB 15
`define RSMO_RELATIVE_CALL_OP_PFX_LSB 11
`define RSMO_RELATIVE_CALL_OP_N_MSB   10
// ----------------------------------------
// phases, pc reset value and pc step
// ----------------------------------------
`define RSMO_PH_ONE        2'h0
`define RSMO_PH_TWO        2'h1
`define RSMO_PH_THREE      2'h2
`define RSMO_PH_FOUR       2'h3
`define RSMO_PC_RST        21'h000000
`define RSMO_PC_STEP       21'h000002
`endif

/* File: src/rsmo_stack.v */
`timescale 1ns/10ps
// ----------------------------------------
// return stack storage, shift style
// ----------------------------------------
module rsmo_stack #(
   parameter WIDTH = 21,
   parameter DEPTH = 31
) (
   input  wire             clk_i,
   input  wire             clr_i,
   input  wire             push_i,
   input  wire             pop_i,
   input  wire [WIDTH-1:0] push_data_i,
   output wire [WIDTH-1:0] top_o
);
   reg [WIDTH-1:0] entry [0:DEPTH-1];
   genvar g;
   generate
      for (g = 0; g < DEPTH; g = g + 1) begin : lvl
         // neighbours picked at elaboration so no level indexes past the array ends
         wire [WIDTH-1:0] from_above;
         wire [WIDTH-1:0] from_below;
         if (g == 0) begin : head
            assign from_above = push_data_i;
         end else begin : tail
            assign from_above = entry[g-1];
         end
         if (g == DEPTH-1) begin : bottom
            assign from_below = {WIDTH{1'b0}};
         end else begin : inner
            assign from_below = entry[g+1];
         end
         always @(posedge clk_i) begin
            if (clr_i) begin
               entry[g] <= {WIDTH{1'b0}};
            end else if (push_i) begin
               entry[g] <= from_above;
            end else if (pop_i) begin
               entry[g] <= from_below;
            end
         end
      end
   endgenerate
   assign top_o = entry[0];
endmodule

/* File: src/rsmo_core.v */
// Functional notes
// - the pop opcode discards the top entry, one word, one cycle.
// - after a pop the top shows the entry pushed just before the discarded one.
// - the push opcode stores pc plus two on top, one word, one cycle, no flag change.
// - a push moves the old top one level down so a later pop recovers it.
// - the relative call takes a signed word offset from -1024 to 1023.
// - the relative call has a five-bit prefix and an 11-bit offset that is doubled.
// - the relative call pushes pc plus two before redirecting.
// - the relative call loads pc with call address plus two plus twice the offset.
// - the relative call is one word and two cycles, the second a no-operation.
// - the reset opcode forces every register and flag to reset, restarting in phase one.
// - each instruction cycle runs four phases: decode, read, process, write.
`timescale 1ns/10ps
`include "rsmo_regs.vh"
module rsmo_core #(
   parameter PC_W  = 21,
   parameter DEPTH = 31
) (
   input  wire            clk_i,
   input  wire            rst_n_i,
   input  wire [15:0]     opcode_i,
   input  wire [7:0]      wreg_i,
   input  wire [7:0]      bank_i,
   input  wire [4:0]      status_i,
   output reg  [PC_W-1:0] pc_o,
   output reg  [PC_W-1:0] stack_top_value_o,
   output reg  [1:0]      phase_o,
   output reg             phase_one_o,
   output reg             phase_four_o,
   output reg             fetch_flush_o,
   output reg             soft_reset_o,
   output reg  [7:0]      wreg_o,
   output reg  [7:0]      bank_o,
   output reg  [4:0]      status_o
);
   // ----------------------------------------
   // phase sequencer and decode
   // ----------------------------------------
   reg  [1:0]      phase;
   reg  [15:0]     ir;
   reg             nop_slot;
   reg             sw_rst;
   wire            is_pop;
   wire            is_push;
   wire            is_relative_call_op;
   wire            is_reset;
   wire [PC_W-1:0] ret_addr;
   wire [PC_W-1:0] offset2;
   wire [PC_W-1:0] stk_top;
   wire            clr;
   wire            st_push;
   wire            st_pop;

   assign clr      = ~rst_n_i | sw_rst;
   // a cycle flagged as the no-op slot decodes nothing
   assign is_pop   = ~nop_slot & (ir == `RSMO_OP_POP);
   assign is_push  = ~nop_slot & (ir == `RSMO_OP_PUSH);
   assign is_reset = ~nop_slot & (ir == `RSMO_OP_RESET);
   assign is_relative_call_op = ~nop_slot &
                     (ir[`RSMO_RELATIVE_CALL_OP_PFX_MSB:`RSMO_RELATIVE_CALL_OP_PFX_LSB] == `RSMO_RELATIVE_CALL_OP_PREFIX);
   assign ret_addr = pc_o + `RSMO_PC_STEP;
   // sign extend n and double it, reach is -1024..1023 words
   assign offset2  = {{(PC_W-12){ir[`RSMO_RELATIVE_CALL_OP_N_MSB]}},
                      ir[`RSMO_RELATIVE_CALL_OP_N_MSB:0], 1'b0};

   // push in phase two, pop in phase three
   assign st_push  = (phase == `RSMO_PH_TWO) & (is_push | is_relative_call_op);
   assign st_pop   = (phase == `RSMO_PH_THREE) & is_pop;

   rsmo_stack #(
      .WIDTH (PC_W),
      .DEPTH (DEPTH)
   ) u_stack (
      .clk_i       (clk_i),
      .clr_i       (clr),
      .push_i      (st_push),
      .pop_i       (st_pop),
      .push_data_i (ret_addr),
      .top_o       (stk_top)
   );

   always @(posedge clk_i) begin
      if (clr) begin
         phase <= `RSMO_PH_ONE;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   // opcode latched in phase one (decode)
   always @(posedge clk_i) begin
      if (clr) begin
         ir <= 16'h0000;
      end else if (phase == `RSMO_PH_ONE) begin
         ir <= opcode_i;
      end
   end

   // software reset raised in phase two, takes effect from the next edge
   always @(posedge clk_i) begin
      if (~rst_n_i) begin
         sw_rst <= 1'b0;
      end else if (sw_rst) begin
         sw_rst <= 1'b0;
      end else begin
         sw_rst <= (phase == `RSMO_PH_TWO) & is_reset;
      end
   end

   // ----------------------------------------
   // program counter and no-op slot
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (clr) begin
         pc_o     <= `RSMO_PC_RST;
         nop_slot <= 1'b0;
      end else if (phase == `RSMO_PH_FOUR) begin
         if (nop_slot) begin
            // the flushed slot must not step pc, or the call target would be skipped
            nop_slot <= 1'b0;
         end else if (is_relative_call_op) begin
            pc_o     <= ret_addr + offset2;
            nop_slot <= 1'b1;
         end else begin
            pc_o     <= ret_addr;
            nop_slot <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always @(posedge clk_i) begin
      if (clr) begin
         stack_top_value_o <= {PC_W{1'b0}};
         phase_o           <= `RSMO_PH_ONE;
         phase_one_o       <= 1'b0;
         phase_four_o      <= 1'b0;
         fetch_flush_o     <= 1'b0;
         soft_reset_o      <= 1'b0;
         wreg_o            <= 8'h00;
         bank_o            <= 8'h00;
         status_o          <= 5'h00;
      end else begin
         stack_top_value_o <= stk_top;
         phase_o           <= phase;
         phase_one_o       <= (phase == `RSMO_PH_ONE);
         phase_four_o      <= (phase == `RSMO_PH_FOUR);
         fetch_flush_o     <= nop_slot;
         soft_reset_o      <= (phase == `RSMO_PH_TWO) & is_reset;
         // these ops pass the working state through untouched
         wreg_o            <= wreg_i;
         bank_o            <= bank_i;
         status_o          <= status_i;
      end
   end
endmodule

/* File: testbench/rsmo_core_props.sv */
`timescale 1ns/10ps
module rsmo_core_props #(
   parameter PC_W  = 21,
   parameter DEPTH = 31
) (
   input wire logic            clk_i,
   input wire logic            rst_n_i,
   input wire logic [7:0]      wreg_i,
   input wire logic [7:0]      bank_i,
   input wire logic [4:0]      status_i,
   input wire logic [PC_W-1:0] pc_o,
   input wire logic [PC_W-1:0] stack_top_value_o,
   input wire logic [1:0]      phase_o,
   input wire logic            phase_one_o,
   input wire logic            phase_four_o,
   input wire logic            fetch_flush_o,
   input wire logic            soft_reset_o,
   input wire logic [7:0]      wreg_o,
   input wire logic [7:0]      bank_o,
   input wire logic [4:0]      status_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_four_after_one: assert property (phase_four_o |-> $past(phase_one_o, 3))
      else $error("phase four without phase one");
   a_four_is_three: assert property (phase_four_o |-> phase_o == 2'h3)
      else $error("phase four marker off");
   a_flush_four: assert property ($rose(fetch_flush_o) |->
      fetch_flush_o[*4] ##1 !fetch_flush_o)
      else $error("flush slot length");
   a_regs_kept: assert property ($past(rst_n_i) && !soft_reset_o && !$past(soft_reset_o)
      && !$past(soft_reset_o, 2) |-> wreg_o == $past(wreg_i) && bank_o == $past(bank_i)
      && status_o == $past(status_i))
      else $error("working regs changed");
   a_sr_pulse: assert property (soft_reset_o |=> !soft_reset_o)
      else $error("soft reset not a pulse");
   a_sr_pc: assert property (soft_reset_o |-> ##[1:2] pc_o == '0)
      else $error("soft reset left pc");
   a_sr_top: assert property (soft_reset_o |-> ##[1:3] stack_top_value_o == '0)
      else $error("soft reset left stack");
   a_rst_vals: assert property (!$past(rst_n_i) |-> pc_o == '0 && stack_top_value_o == '0)
      else $error("reset values wrong");
   c_flush: cover property ($rose(fetch_flush_o));
   c_sr: cover property (soft_reset_o);
   c_four: cover property (phase_four_o);
endmodule
bind rsmo_core rsmo_core_props #(.PC_W(PC_W), .DEPTH(DEPTH)) u_props (.*);

/* File: testbench/rsmo_core_tb.sv */
`timescale 1ns/10ps
`include "rsmo_regs.vh"
module rsmo_core_tb;
   logic clk_i = 0, rst_n_i = 0;
   logic [15:0] opcode_i = '0;
   logic [7:0] wreg_i = 8'h5A, bank_i = 8'hC3;
   logic [4:0] status_i = 5'h15;
   wire [20:0] pc_o, top;
   wire [7:0] wreg_o, bank_o;
   wire [4:0] status_o;
   wire ph_o1, ph_o4, flush, sr;
   wire [1:0] phase_o;
   int num_errors = 0, n_checks = 0, n_sr = 0;
   rsmo_core u_rsmo_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .opcode_i(opcode_i),
      .wreg_i(wreg_i), .bank_i(bank_i), .status_i(status_i), .pc_o(pc_o),
      .stack_top_value_o(top), .phase_o(phase_o), .phase_one_o(ph_o1),
      .phase_four_o(ph_o4), .fetch_flush_o(flush), .soft_reset_o(sr),
      .wreg_o(wreg_o), .bank_o(bank_o), .status_o(status_o));
   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) if (sr === 1'b1) n_sr++;
   task chk(input logic [20:0] a, e);
      n_checks++;
      if (a !== e) begin
         num_errors++;
         $display("mismatch %0t got %h exp %h", $time, a, e);
      end
   endtask
   // one instruction cycle per call, opcode held all four phases
   task op(input logic [15:0] o);
      opcode_i = o;
      repeat (4) @(negedge clk_i);
   endtask
   task t_push_pop;
      op(`RSMO_OP_PUSH); chk(top, 21'h2);
      wreg_i = 8'h3C;
      op(`RSMO_OP_PUSH); chk(top, 21'h4); chk(pc_o, 21'h4);
      chk({wreg_o, bank_o, status_o}, {8'h3C, 8'hC3, 5'h15});
      op(`RSMO_OP_POP); chk(top, 21'h2); chk(pc_o, 21'h6);
   endtask
   task t_relative_call_op;
      op({5'h1B, 11'h7FD}); chk(top, 21'h8); chk(pc_o, 21'h2);
      op(`RSMO_OP_PUSH); chk(top, 21'h8);
      chk(pc_o, 21'h2);
      op({5'h1B, 11'h3FF}); chk(top, 21'h4); chk(pc_o, 21'h802);
      op('0); chk(pc_o, 21'h802);
      op({5'h1B, 11'h400}); chk(top, 21'h804); chk(pc_o, 21'h4);
      op('0);
   endtask
   task t_reset;
      opcode_i = `RSMO_OP_RESET;
      repeat (2) @(negedge clk_i);
      opcode_i = '0;
      repeat (3) @(negedge clk_i);
      chk(top, 21'h0); chk(pc_o, 21'h0); chk(n_sr, 21'h1);
   endtask
   task wrap_up;
      if (num_errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #10000;
      num_errors++;
      wrap_up;
   end
   initial begin
      repeat (6) @(negedge clk_i);
      rst_n_i = 1;
      t_push_pop;
      t_relative_call_op;
      t_reset;
      wrap_up;
   end
endmodule
